//--- hdl/ref_input_group_selection.sv
`timescale 1ns/1ps
module ref_input_group_selection #(
  parameter int FRAME_CYCLES = ref_select_pkg::FRAME_CYCLES
) (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                csb_n,
  input  wire logic                sclk,
  input  wire logic                sdi,
  output logic                     sdo,
  input  wire logic                master_ref_valid,
  input  wire logic                slave_ref_valid,
  input  wire logic                master_diff_valid,
  input  wire logic                slave_diff_valid,
  input  wire logic                standby_ref_valid,
  input  wire logic                master_frame_pulse_in,
  input  wire logic                slave_frame_pulse_in,
  input  wire logic                standby_frame_pulse_in,
  input  wire logic                fast_switch_slave,
  input  wire logic                network_type_pin,
  input  wire logic [31:0]         measured_freq,
  output logic [31:0]              loop_freq_word,
  output ref_select_pkg::mode_type loop_mode,
  output logic [3:0]               sel_clock_channel,
  output logic [3:0]               sel_sync_channel,
  output logic                     network_type_select,
  output logic [5:0]               out1_freq_sel,
  output logic [5:0]               out2_freq_sel,
  output logic                     frame_pulse_out,
  output logic                     multiframe_pulse_out
);
  import ref_select_pkg::*;

  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_s1;
  logic [NUM_PINS-1:0] pin_s2;
  logic [NUM_PINS-1:0] pin_s3;
  logic [NUM_PINS-1:0] pin_filt;
  logic [NUM_PINS-1:0] pin_prev;
  logic [NUM_PINS-1:0] pin_rise;
  logic [NUM_PINS-1:0] pin_fall;
  logic [4:0]          bit_count;
  logic [7:0]          cmd;
  logic [7:0]          data_sh;
  logic [7:0]          rd_sh;
  logic [7:0]          rd_data;
  logic [6:0]          rd_addr;
  logic                rd_load;
  logic                wr_strobe;
  logic [6:0]          wr_addr;
  logic [7:0]          wr_data;
  logic [7:0]          prio_a;
  logic [7:0]          prio_b;
  logic [7:0]          prio_c;
  logic [7:0]          freq_cfg [NUM_REFS];
  logic [7:0]          in_mode;
  logic [7:0]          diff_cfg;
  logic [7:0]          calib;
  logic [2:0]          strap_count;
  logic                strap_load;
  logic [3:0]          prio [NUM_REFS];
  logic [NUM_REFS-1:0] ref_valid;
  logic [NUM_REFS-1:0] port_ok;
  logic [NUM_REFS-1:0] eligible;
  logic [NUM_REFS-1:0] cand_ok;
  logic                ms_failed;
  logic                any_ok;
  logic [IDX_W-1:0]    best_idx;
  logic [IDX_W-1:0]    cur_idx;
  logic [31:0]         held_freq;
  logic                sync_hit;
  logic                sync_align;

  function automatic logic [3:0] clock_chan(input logic [IDX_W-1:0] idx);
    clock_chan = CH_STBY;
    if (idx == REF_M_SE) clock_chan = CH_M_SE;
    else if (idx == REF_S_SE) clock_chan = CH_S_SE;
    else if (idx == REF_M_DIF) clock_chan = CH_M_DIF;
    else if (idx == REF_S_DIF) clock_chan = CH_S_DIF;
  endfunction

  function automatic logic [3:0] sync_chan(input logic [IDX_W-1:0] idx);
    sync_chan = CH_B_SYNC;
    if (idx == REF_M_SE || idx == REF_M_DIF) sync_chan = CH_M_SYNC;
    else if (idx == REF_S_SE || idx == REF_S_DIF) sync_chan = CH_S_SYNC;
  endfunction

  function automatic logic freq_ok(input logic [7:0] cfg, input logic diff);
    freq_ok = cfg[DIVN_BIT] || (cfg[3:0] <= FREQ_MAX_SE) || (diff && cfg[3:0] == FREQ_155M);
  endfunction

  // pins: three stages, filtered value moves only when stages two and three agree
  assign pin_raw = {network_type_pin, fast_switch_slave, standby_frame_pulse_in,
                    slave_frame_pulse_in, master_frame_pulse_in, sdi, sclk, csb_n};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_s1   <= PIN_RESET;
      pin_s2   <= PIN_RESET;
      pin_s3   <= PIN_RESET;
      pin_filt <= PIN_RESET;
      pin_prev <= PIN_RESET;
    end else begin
      pin_s1   <= pin_raw;
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_filt <= (pin_filt & (pin_s2 ^ pin_s3)) | (pin_s3 & ~(pin_s2 ^ pin_s3));
      pin_prev <= pin_filt;
    end
  end

  assign pin_rise = pin_filt & ~pin_prev;
  assign pin_fall = ~pin_filt & pin_prev;

  // serial port: command byte (read flag, 7-bit address) then one data byte
  assign rd_addr   = {cmd[5:0], pin_filt[PIN_SDI]};
  assign rd_load   = !pin_filt[PIN_CSB] && pin_rise[PIN_SCLK] &&
                     bit_count == SPI_CMD_BITS - 5'h01 && cmd[6];
  assign wr_strobe = !pin_filt[PIN_CSB] && pin_rise[PIN_SCLK] &&
                     bit_count == SPI_BITS - 5'h01 && !cmd[7];
  assign wr_addr   = cmd[6:0];
  assign wr_data   = {data_sh[6:0], pin_filt[PIN_SDI]};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_count <= '0;
      cmd       <= '0;
      data_sh   <= '0;
    end else if (pin_filt[PIN_CSB]) begin
      bit_count <= '0;
    end else if (pin_rise[PIN_SCLK] && bit_count != SPI_BITS) begin
      if (bit_count < SPI_CMD_BITS) begin
        cmd <= {cmd[6:0], pin_filt[PIN_SDI]};
      end else begin
        data_sh <= {data_sh[6:0], pin_filt[PIN_SDI]};
      end
      bit_count <= bit_count + 5'h01;
    end
  end

  // first read bit must be out before the ninth rising edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_sh <= '0;
      sdo   <= 1'b0;
    end else if (pin_filt[PIN_CSB]) begin
      sdo <= 1'b0;
    end else if (rd_load) begin
      rd_sh <= rd_data;
      sdo   <= rd_data[7];
    end else if (pin_fall[PIN_SCLK] && bit_count > SPI_CMD_BITS) begin
      rd_sh <= {rd_sh[6:0], 1'b0};
      sdo   <= rd_sh[6];
    end
  end

  always_comb begin
    rd_data = '0;
    if (rd_addr == ADDR_PRIO_A) rd_data = prio_a;
    else if (rd_addr == ADDR_PRIO_B) rd_data = prio_b;
    else if (rd_addr == ADDR_PRIO_C) rd_data = prio_c;
    else if (rd_addr == ADDR_FREQ_0) rd_data = freq_cfg[0];
    else if (rd_addr == ADDR_FREQ_1) rd_data = freq_cfg[1];
    else if (rd_addr == ADDR_FREQ_2) rd_data = freq_cfg[2];
    else if (rd_addr == ADDR_FREQ_3) rd_data = freq_cfg[3];
    else if (rd_addr == ADDR_FREQ_4) rd_data = freq_cfg[4];
    else if (rd_addr == ADDR_IN_MODE) rd_data = in_mode;
    else if (rd_addr == ADDR_DIFF) rd_data = diff_cfg;
    else if (rd_addr == ADDR_CALIB) rd_data = calib;
    else if (rd_addr == ADDR_STATUS) rd_data = {sel_clock_channel, 1'b0, loop_mode};
    else if (rd_addr == ADDR_OUT1) rd_data = {2'b00, out1_freq_sel};
    else if (rd_addr == ADDR_OUT2) rd_data = {2'b00, out2_freq_sel};
  end

  // strap sampled only once the pin filter has settled after release
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_count <= '0;
    end else if (strap_count != STRAP_DONE) begin
      strap_count <= strap_count + 3'h1;
    end
  end

  assign strap_load = strap_count == STRAP_WAIT;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prio_a        <= PRIO_A_RESET;
      prio_b        <= PRIO_B_RESET;
      prio_c        <= PRIO_C_RESET;
      freq_cfg[0]   <= FREQ_8K_CFG;
      freq_cfg[1]   <= FREQ_8K_CFG;
      freq_cfg[2]   <= FREQ_19M_CFG;
      freq_cfg[3]   <= FREQ_19M_CFG;
      freq_cfg[4]   <= FREQ_19M_CFG;
      in_mode       <= '0;
      diff_cfg      <= '0;
      calib         <= '0;
      out1_freq_sel <= '0;
      out2_freq_sel <= '0;
    end else begin
      if (strap_load) begin
        in_mode[NET_BIT] <= pin_filt[PIN_NET];
      end else if (wr_strobe && wr_addr == ADDR_IN_MODE) begin
        in_mode <= wr_data;
      end
      if (wr_strobe) begin
        if (wr_addr == ADDR_PRIO_A) prio_a <= wr_data;
        else if (wr_addr == ADDR_PRIO_B) prio_b <= wr_data;
        else if (wr_addr == ADDR_PRIO_C) prio_c <= wr_data;
        else if (wr_addr == ADDR_FREQ_0) freq_cfg[0] <= wr_data;
        else if (wr_addr == ADDR_FREQ_1) freq_cfg[1] <= wr_data;
        else if (wr_addr == ADDR_FREQ_2) freq_cfg[2] <= wr_data;
        else if (wr_addr == ADDR_FREQ_3) freq_cfg[3] <= wr_data;
        else if (wr_addr == ADDR_FREQ_4) freq_cfg[4] <= wr_data;
        else if (wr_addr == ADDR_DIFF) diff_cfg <= wr_data;
        else if (wr_addr == ADDR_CALIB) calib <= wr_data;
        else if (wr_addr == ADDR_OUT1) begin
          out1_freq_sel <= (wr_data[5:0] > OUT_FREQ_MAX) ? OUT_FREQ_MAX : wr_data[5:0];
        end else if (wr_addr == ADDR_OUT2) begin
          out2_freq_sel <= (wr_data[5:0] > OUT_FREQ_MAX) ? OUT_FREQ_MAX : wr_data[5:0];
        end
      end
    end
  end

  assign network_type_select = in_mode[NET_BIT];

  // qualification of the five clock ports
  assign ref_valid = {standby_ref_valid, slave_diff_valid, master_diff_valid,
                      slave_ref_valid, master_ref_valid};
  assign prio[0]   = prio_a[PRIO_W-1:0];
  assign prio[1]   = prio_a[2*PRIO_W-1:PRIO_W];
  assign prio[2]   = prio_b[PRIO_W-1:0];
  assign prio[3]   = prio_b[2*PRIO_W-1:PRIO_W];
  assign prio[4]   = prio_c[PRIO_W-1:0];
  assign port_ok   = {1'b1, diff_cfg[1], diff_cfg[0], !diff_cfg[1], !diff_cfg[0]};

  assign eligible[REF_M_SE]  = ref_valid[REF_M_SE] && port_ok[REF_M_SE] &&
                               prio[REF_M_SE] != '0 && !pin_filt[PIN_FORCE] &&
                               freq_ok(freq_cfg[REF_M_SE], 1'b0);
  assign eligible[REF_S_SE]  = ref_valid[REF_S_SE] && port_ok[REF_S_SE] &&
                               prio[REF_S_SE] != '0 && freq_ok(freq_cfg[REF_S_SE], 1'b0);
  assign eligible[REF_M_DIF] = ref_valid[REF_M_DIF] && port_ok[REF_M_DIF] &&
                               prio[REF_M_DIF] != '0 && !pin_filt[PIN_FORCE] &&
                               freq_ok(freq_cfg[REF_M_DIF], 1'b1);
  assign eligible[REF_S_DIF] = ref_valid[REF_S_DIF] && port_ok[REF_S_DIF] &&
                               prio[REF_S_DIF] != '0 && freq_ok(freq_cfg[REF_S_DIF], 1'b1);
  assign eligible[REF_STBY]  = ref_valid[REF_STBY] && prio[REF_STBY] != '0 &&
                               freq_ok(freq_cfg[REF_STBY], 1'b0);

  assign ms_failed = !(|(ref_valid[REF_S_DIF:REF_M_SE] & port_ok[REF_S_DIF:REF_M_SE]));
  // standby is taken on master and slave loss even with priority zero
  assign cand_ok   = eligible | {ms_failed && ref_valid[REF_STBY], 4'h0};

  always_comb begin
    logic [3:0] best_prio;
    logic [3:0] eff;
    best_prio = PRIO_LAST;
    eff       = PRIO_LAST;
    best_idx  = REF_STBY;
    any_ok    = 1'b0;
    for (int i = 0; i < NUM_REFS; i++) begin
      eff = (prio[i] == '0) ? PRIO_LAST : prio[i];
      if (cand_ok[i] && (!any_ok || eff < best_prio)) begin
        best_prio = eff;
        best_idx  = IDX_W'(i);
        any_ok    = 1'b1;
      end
    end
  end

  // non-revertive: a working reference is kept until it is disqualified
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      loop_mode         <= FREE_RUN;
      cur_idx           <= REF_STBY;
      sel_clock_channel <= CH_NONE;
      sel_sync_channel  <= CH_NONE;
    end else begin
      case (loop_mode)
        FREE_RUN, HOLDOVER: begin
          if (any_ok) begin
            loop_mode         <= LOCKED;
            cur_idx           <= best_idx;
            sel_clock_channel <= clock_chan(best_idx);
            sel_sync_channel  <= sync_chan(best_idx);
          end
        end
        LOCKED: begin
          if (!cand_ok[cur_idx]) begin
            if (any_ok) begin
              cur_idx           <= best_idx;
              sel_clock_channel <= clock_chan(best_idx);
              sel_sync_channel  <= sync_chan(best_idx);
            end else begin
              loop_mode <= HOLDOVER;
            end
          end
        end
        default: loop_mode <= FREE_RUN;
      endcase
    end
  end

  // loop runs on the oscillator clock, so free-run stability is the oscillator's
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      loop_freq_word <= NOMINAL_WORD;
      held_freq      <= NOMINAL_WORD;
    end else begin
      if (loop_mode == LOCKED) begin
        held_freq      <= measured_freq;
        loop_freq_word <= measured_freq;
      end else if (loop_mode == HOLDOVER) begin
        loop_freq_word <= held_freq;
      end else begin
        loop_freq_word <= NOMINAL_WORD + {{24{calib[7]}}, calib};
      end
    end
  end

  always_comb begin
    sync_hit = pin_rise[PIN_SYNC_B];
    if (sel_sync_channel == CH_M_SYNC) sync_hit = pin_rise[PIN_SYNC_M];
    else if (sel_sync_channel == CH_S_SYNC) sync_hit = pin_rise[PIN_SYNC_S];
  end

  assign sync_align = sync_hit && loop_mode == LOCKED;

  pulse_divider #(.PERIOD(FRAME_CYCLES)) frame_gen (
    .clock (clock),
    .rstn  (rstn),
    .tick  (1'b1),
    .align (sync_align),
    .pulse (frame_pulse_out)
  );

  pulse_divider #(.PERIOD(FRAMES_PER_MULTI)) multiframe_gen (
    .clock (clock),
    .rstn  (rstn),
    .tick  (frame_pulse_out && !multiframe_pulse_out), // align's own frame is not a new one
    .align (sync_align),
    .pulse (multiframe_pulse_out)
  );

  sync_pairing_a: assert property (@(posedge clock) disable iff (!rstn)
    loop_mode == LOCKED |-> sel_sync_channel == sync_chan(cur_idx))
    else $error("sync channel not from the selected group");

  fast_switch_a: assert property (@(posedge clock) disable iff (!rstn)
    pin_filt[PIN_FORCE] && $past(pin_filt[PIN_FORCE]) && loop_mode == LOCKED
    |-> cur_idx != REF_M_SE && cur_idx != REF_M_DIF)
    else $error("master kept while slave forced");

  standby_fallback_a: assert property (@(posedge clock) disable iff (!rstn)
    ms_failed && standby_ref_valid |=> sel_clock_channel == CH_STBY && loop_mode == LOCKED)
    else $error("standby not selected after master and slave loss");

  holdover_entry_a: assert property (@(posedge clock) disable iff (!rstn)
    loop_mode == LOCKED && ms_failed && !standby_ref_valid |=> loop_mode == HOLDOVER)
    else $error("holdover not entered");

  free_run_word_a: assert property (@(posedge clock) disable iff (!rstn)
    loop_mode == FREE_RUN |=>
    loop_freq_word == NOMINAL_WORD + {{24{$past(calib[7])}}, $past(calib)})
    else $error("free-run word not trimmed nominal");

  locked_track_a: assert property (@(posedge clock) disable iff (!rstn)
    loop_mode == LOCKED |=> loop_freq_word == $past(measured_freq))
    else $error("locked word not tracking measurement");

  holdover_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    loop_mode == HOLDOVER && $past(loop_mode) == HOLDOVER |=> $stable(loop_freq_word))
    else $error("holdover word drifted");

  strap_load_a: assert property (@(posedge clock) disable iff (!rstn)
    strap_load |=> network_type_select == $past(pin_filt[PIN_NET]))
    else $error("network type not loaded from pin");
endmodule

//--- hdl/ref_select_pkg.sv
// Functional notes
// - clock and sync selections always change together, from one group.
// - the fast-switch pin overrides automatic master/slave choice.
// - master and slave both failed selects the standby group.
// - all three groups unavailable enters digital holdover.
// - free-run output uses oscillator accuracy plus a software trim.
// - locked mode picks the best reference and tracks it.
// - holdover keeps the last frequency measured on the old reference.
// - the digital loop runs on the external oscillator clock.
// - 8-bit registers at two-digit hex addresses over an SPI-like port.
// - bit 2 of address 34 picks SONET when one, SDH when zero.
// - the network bit loads from its pin at reset, then software owns it.
// - every input port carries its fixed 4-bit channel number.
// - default priorities 2, 3, 0, 0, 4; sync inputs have none.
// - single-ended default 8 kHz; differential and standby default 19.44 MHz.
// - single-ended inputs lock directly to the listed spot frequencies.
// - differential inputs add 155.52 MHz to the single-ended set.
// - any multiple of 8 kHz locks through the programmable divider.
// - two output clocks, each selectable from 53 frequencies.
// - 8 kHz frame and 2 kHz multiframe pulses follow the selected group.
// - a disqualified reference gives way to the next qualified priority.
package ref_select_pkg;
  localparam int CLOCK_HZ         = 125_000_000;
  localparam int FRAME_HZ         = 8000;
  localparam int MULTIFRAME_HZ    = 2000;
  localparam int FRAME_CYCLES     = CLOCK_HZ / FRAME_HZ;
  localparam int FRAMES_PER_MULTI = FRAME_HZ / MULTIFRAME_HZ;

  localparam logic [6:0] ADDR_PRIO_A  = 7'h19;
  localparam logic [6:0] ADDR_PRIO_B  = 7'h1a;
  localparam logic [6:0] ADDR_PRIO_C  = 7'h1c;
  localparam logic [6:0] ADDR_FREQ_0  = 7'h22;
  localparam logic [6:0] ADDR_FREQ_1  = 7'h23;
  localparam logic [6:0] ADDR_FREQ_2  = 7'h24;
  localparam logic [6:0] ADDR_FREQ_3  = 7'h25;
  localparam logic [6:0] ADDR_FREQ_4  = 7'h28;
  localparam logic [6:0] ADDR_IN_MODE = 7'h34;
  localparam logic [6:0] ADDR_DIFF    = 7'h36;
  localparam logic [6:0] ADDR_CALIB   = 7'h3c;
  localparam logic [6:0] ADDR_STATUS  = 7'h3d;
  localparam logic [6:0] ADDR_OUT1    = 7'h60;
  localparam logic [6:0] ADDR_OUT2    = 7'h61;

  localparam logic [7:0] PRIO_A_RESET = 8'h32;
  localparam logic [7:0] PRIO_B_RESET = 8'h00;
  localparam logic [7:0] PRIO_C_RESET = 8'h04;
  localparam logic [7:0] FREQ_8K_CFG  = 8'h02;
  localparam logic [7:0] FREQ_19M_CFG = 8'h05;
  localparam logic [3:0] FREQ_MAX_SE  = 4'h9;
  localparam logic [3:0] FREQ_155M    = 4'ha;
  localparam int         DIVN_BIT     = 7;
  localparam int         NET_BIT      = 2;
  localparam int         PRIO_W       = 4;
  localparam logic [3:0] PRIO_LAST    = 4'hf;
  localparam logic [5:0] OUT_FREQ_MAX = 6'h34;

  localparam int         NUM_REFS  = 5;
  localparam int         IDX_W     = 3;
  localparam logic [2:0] REF_M_SE  = 3'h0;
  localparam logic [2:0] REF_S_SE  = 3'h1;
  localparam logic [2:0] REF_M_DIF = 3'h2;
  localparam logic [2:0] REF_S_DIF = 3'h3;
  localparam logic [2:0] REF_STBY  = 3'h4;

  localparam logic [3:0] CH_NONE   = 4'h0;
  localparam logic [3:0] CH_M_SE   = 4'h3;
  localparam logic [3:0] CH_S_SE   = 4'h4;
  localparam logic [3:0] CH_M_DIF  = 4'h5;
  localparam logic [3:0] CH_S_DIF  = 4'h6;
  localparam logic [3:0] CH_M_SYNC = 4'h7;
  localparam logic [3:0] CH_S_SYNC = 4'h8;
  localparam logic [3:0] CH_STBY   = 4'h9;
  localparam logic [3:0] CH_B_SYNC = 4'ha;

  localparam int         NUM_PINS   = 8;
  localparam logic [7:0] PIN_RESET  = 8'h01;
  localparam int         PIN_CSB    = 0;
  localparam int         PIN_SCLK   = 1;
  localparam int         PIN_SDI    = 2;
  localparam int         PIN_SYNC_M = 3;
  localparam int         PIN_SYNC_S = 4;
  localparam int         PIN_SYNC_B = 5;
  localparam int         PIN_FORCE  = 6;
  localparam int         PIN_NET    = 7;
  localparam logic [2:0] STRAP_WAIT = 3'h4;
  localparam logic [2:0] STRAP_DONE = 3'h5;

  localparam logic [4:0] SPI_CMD_BITS = 5'h08;
  localparam logic [4:0] SPI_BITS     = 5'h10;

  localparam logic [31:0] NOMINAL_WORD = 32'h4000_0000;

  typedef enum logic [2:0] {
    FREE_RUN = 3'b001,
    LOCKED   = 3'b010,
    HOLDOVER = 3'b100
  } mode_type;
endpackage

//--- hdl/pulse_divider.sv
`timescale 1ns/1ps
module pulse_divider #(
  parameter int PERIOD = 4
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic tick,
  input  wire logic align,
  output logic      pulse
);
  localparam int            W    = $clog2(PERIOD);
  localparam logic [W-1:0]  LAST = W'(PERIOD - 1);

  logic [W-1:0] count;

  // align restarts the period so output edges track the chosen sync input
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (align) begin
        count <= '0;
        pulse <= 1'b1;
      end else if (tick) begin
        if (count == LAST) begin
          count <= '0;
          pulse <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule

//--- dv/card_model.sv
`timescale 1ns/1ps
module card_model (
  input  wire logic       clock,
  input  wire logic [2:0] ok,
  output logic      [4:0] valid,
  output logic      [2:0] sync
);
  logic [6:0] cnt = 7'h00;
  always_ff @(posedge clock) cnt <= (cnt == 7'h4f) ? 7'h00 : cnt + 7'h01;
  // a failed card loses qualification at once; diff ports are not fitted
  assign valid = {ok[2], 2'b00, ok[1], ok[0]};
  // one sync pulse per multiframe, silent once the card has failed
  assign sync = ok & {3{cnt < 7'h04}};
endmodule

//--- dv/ref_input_group_selection_tb.sv
`timescale 1ns/1ps
module ref_input_group_selection_tb;
  import ref_select_pkg::*;
  logic clock, rstn, csb_n, sclk, sdi, sdo, fast, npin, nts, fp, mfp;
  logic [2:0] ok, sync;
  logic [4:0] valid;
  logic [31:0] word, meas;
  logic [5:0] o1, o2;
  mode_type mode;
  logic [3:0] cch, sch;
  logic [7:0] rd;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  card_model cards (.clock(clock), .ok(ok), .valid(valid), .sync(sync));
  ref_input_group_selection #(.FRAME_CYCLES(20)) dut (
    .clock(clock), .rstn(rstn), .csb_n(csb_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .master_ref_valid(valid[0]), .slave_ref_valid(valid[1]), .master_diff_valid(valid[2]),
    .slave_diff_valid(valid[3]), .standby_ref_valid(valid[4]),
    .master_frame_pulse_in(sync[0]), .slave_frame_pulse_in(sync[1]),
    .standby_frame_pulse_in(sync[2]), .fast_switch_slave(fast), .network_type_pin(npin),
    .measured_freq(meas), .loop_freq_word(word), .loop_mode(mode),
    .sel_clock_channel(cch), .sel_sync_channel(sch), .network_type_select(nts),
    .out1_freq_sel(o1), .out2_freq_sel(o2), .frame_pulse_out(fp), .multiframe_pulse_out(mfp));
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // slow bit-bang: the pin filter needs several clocks per level
  task automatic spi(input logic [7:0] c, input logic [7:0] d);
    logic [15:0] w;
    w = {c, d};
    @(posedge clock) csb_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi <= w[i];
      repeat (8) @(posedge clock);
      #1 if (i < 8) rd = {rd[6:0], sdo};
      @(posedge clock) sclk <= 1'b1;
      repeat (8) @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge clock);
    csb_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
  task automatic chk_sel(input logic [3:0] c, input logic [3:0] s, input mode_type m,
                         input logic [31:0] w);
    repeat (10) @(posedge clock);
    #1 chk("clock channel", c, cch);
    chk("sync channel", s, sch);
    chk("mode", m, mode);
    chk("loop word", w, word);
    @(posedge clock);
  endtask
  task automatic defaults();
    chk("net bit", 1, nts);
    chk_sel(4'h0, 4'h0, FREE_RUN, NOMINAL_WORD);
    spi(8'h3c, 8'hff);
    chk_sel(4'h0, 4'h0, FREE_RUN, NOMINAL_WORD - 32'h0000_0001);
    spi(8'h60, 8'h3f);
    spi(8'h61, 8'h05);
    #1 chk("out1 sel", OUT_FREQ_MAX, o1);
    chk("out2 sel", 6'h05, o2);
    spi(8'h99, 8'h00);
    chk("prio a", 8'h32, rd);
    spi(8'h9a, 8'h00);
    chk("prio b", 8'h00, rd);
    spi(8'h9c, 8'h00);
    chk("prio c", 8'h04, rd);
    spi(8'ha2, 8'h00);
    chk("freq 0", 8'h02, rd);
    spi(8'ha8, 8'h00);
    chk("freq 4", 8'h05, rd);
    spi(8'hff, 8'h00);
    chk("unmapped", 8'h00, rd);
  endtask
  task automatic failover();
    spi(8'h19, 8'h12);
    spi(8'h99, 8'h00);
    chk("prio a", 8'h12, rd);
    ok <= 3'b111;
    chk_sel(CH_S_SE, CH_S_SYNC, LOCKED, 32'h0000_1234);
    ok <= 3'b101;
    meas <= 32'h0000_5678;
    chk_sel(CH_M_SE, CH_M_SYNC, LOCKED, 32'h0000_5678);
    ok <= 3'b100;
    chk_sel(CH_STBY, CH_B_SYNC, LOCKED, 32'h0000_5678);
    ok <= 3'b000;
    chk_sel(CH_STBY, CH_B_SYNC, HOLDOVER, 32'h0000_5678);
    meas <= 32'h0000_9abc;
    chk_sel(CH_STBY, CH_B_SYNC, HOLDOVER, 32'h0000_5678);
  endtask
  task automatic force_slave();
    spi(8'h19, 8'h21);
    fast <= 1'b1;
    ok <= 3'b111;
    chk_sel(CH_S_SE, CH_S_SYNC, LOCKED, 32'h0000_9abc);
  endtask
  task automatic net_write();
    spi(8'hb4, 8'h00);
    chk("mode reg bit", 1, rd[2]);
    spi(8'h34, rd & 8'hfb);
    #1 chk("net bit", 0, nts);
  endtask
  task automatic frames();
    int f;
    int m;
    f = 0;
    m = 0;
    repeat (160) begin
      @(posedge clock);
      #1 f += int'(fp === 1'b1);
      m += int'(mfp === 1'b1);
    end
    chk("frame pulses", 8, f);
    chk("multiframes", 2, m);
  endtask
  // slave moved to its unfitted diff port, then standby given an unsupported rate
  task automatic ports();
    spi(8'h36, 8'h02);
    chk_sel(CH_STBY, CH_B_SYNC, LOCKED, 32'h0000_9abc);
    spi(8'h28, 8'h0b);
    chk_sel(CH_STBY, CH_B_SYNC, HOLDOVER, 32'h0000_9abc);
  endtask
  initial begin
    rstn = 0; csb_n = 1; sclk = 0; sdi = 0; ok = 0; fast = 0; npin = 1; rd = 0;
    meas = 32'h0000_1234;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    repeat (12) @(posedge clock);
    defaults();
    failover();
    force_slave();
    net_write();
    frames();
    ports();
    summarize();
  end
endmodule
